// ==== sfef_filter.sv ====
// falling-edge transition masks of the five status register sets
// assumes condition bits and commands come from logic on sys_clk;
// event outputs are one-cycle set strobes into event registers kept elsewhere
module sfef_filter
	import sfef_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire sfef_cmd_type cmd,
	input wire logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] cond,
	output logic cmd_ready,
	output sfef_resp_type resp,
	output logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] event_set
);

	typedef struct packed {
		logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] mask;
		logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] cond_prev;
		logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] ev;
		logic busy;
		logic ready;
		sfef_resp_type resp;
	} sfef_state_type;

	sfef_state_type st_r;
	sfef_state_type st_nxt;

	logic conv_start;
	logic conv_done;
	logic [SFEF_BCD_W-1:0] conv_bcd;
	logic [SFEF_MASK_W-1:0] conv_bin;
	logic accept;
	logic [16:0] wr_value;
	logic wr_digits_ok;

	////////////////////////////////////////////////////////////////////////////

	function automatic logic sfef_sel_ok(input sfef_set_type s);
		return s <= SFEF_QUES;
	endfunction

	// one-to-zero change of a condition bit, gated by its mask bit
	function automatic logic sfef_fall(input logic [SFEF_MASK_W-1:0] prev,
		input logic [SFEF_MASK_W-1:0] cur, input logic [SFEF_MASK_W-1:0] m, input int b);
		return m[b] & prev[b] & ~cur[b]; // RULE_02
	endfunction

	// the host's decimal sum of weights, sent as five packed digits
	always_comb begin
		wr_digits_ok = 1'b1;
		for (int i = 0; i < SFEF_BCD_W / 4; i++) begin
			if (cmd.bcd[i*4 +: 4] > 4'h9) begin
				wr_digits_ok = 1'b0;
			end
		end
		wr_value = 17'(cmd.bcd[19:16]) * 17'd10000 + 17'(cmd.bcd[15:12]) * 17'd1000
			+ 17'(cmd.bcd[11:8]) * 17'd100 + 17'(cmd.bcd[7:4]) * 17'd10
			+ 17'(cmd.bcd[3:0]); // RULE_04
	end

	assign accept = st_r.ready & (cmd.wr | cmd.rd | cmd.preset | cmd.clr_status);
	assign conv_start = accept & ~cmd.preset & ~cmd.wr & cmd.rd & sfef_sel_ok(cmd.sel);
	assign conv_bin = sfef_sel_ok(cmd.sel) ? st_r.mask[cmd.sel] : SFEF_MASK_RESET;

	sfef_bin2bcd u_bin2bcd (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(conv_start),
		.bin(conv_bin),
		.done(conv_done),
		.bcd(conv_bcd)
	);

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_nxt = st_r;
		st_nxt.resp.valid = 1'b0;
		st_nxt.resp.err = 1'b0;
		st_nxt.cond_prev = cond;

		// filtering keeps running while a query converts
		st_nxt.ev = '0;
		st_nxt.ev[SFEF_OPER][SFEF_OPER_SETTLE] = sfef_fall(st_r.cond_prev[SFEF_OPER],
			cond[SFEF_OPER], st_r.mask[SFEF_OPER], SFEF_OPER_SETTLE); // RULE_07
		st_nxt.ev[SFEF_OPER][SFEF_OPER_TRIG] = sfef_fall(st_r.cond_prev[SFEF_OPER],
			cond[SFEF_OPER], st_r.mask[SFEF_OPER], SFEF_OPER_TRIG); // RULE_08
		st_nxt.ev[SFEF_OPER][SFEF_OPER_ARM] = sfef_fall(st_r.cond_prev[SFEF_OPER],
			cond[SFEF_OPER], st_r.mask[SFEF_OPER], SFEF_OPER_ARM); // RULE_09
		st_nxt.ev[SFEF_OPER][SFEF_OPER_IDLE] = sfef_fall(st_r.cond_prev[SFEF_OPER],
			cond[SFEF_OPER], st_r.mask[SFEF_OPER], SFEF_OPER_IDLE); // RULE_10
		st_nxt.ev[SFEF_TRIG][SFEF_TRIG_SEQ1] = sfef_fall(st_r.cond_prev[SFEF_TRIG],
			cond[SFEF_TRIG], st_r.mask[SFEF_TRIG], SFEF_TRIG_SEQ1); // RULE_11
		st_nxt.ev[SFEF_ARM][SFEF_ARM_SEQ1] = sfef_fall(st_r.cond_prev[SFEF_ARM],
			cond[SFEF_ARM], st_r.mask[SFEF_ARM], SFEF_ARM_SEQ1); // RULE_12
		st_nxt.ev[SFEF_SEQ][SFEF_SEQ_LAYER1] = sfef_fall(st_r.cond_prev[SFEF_SEQ],
			cond[SFEF_SEQ], st_r.mask[SFEF_SEQ], SFEF_SEQ_LAYER1); // RULE_13
		st_nxt.ev[SFEF_SEQ][SFEF_SEQ_LAYER2] = sfef_fall(st_r.cond_prev[SFEF_SEQ],
			cond[SFEF_SEQ], st_r.mask[SFEF_SEQ], SFEF_SEQ_LAYER2); // RULE_13
		st_nxt.ev[SFEF_QUES][SFEF_QUES_CHAN] = sfef_fall(st_r.cond_prev[SFEF_QUES],
			cond[SFEF_QUES], st_r.mask[SFEF_QUES], SFEF_QUES_CHAN); // RULE_14
		// RULE_03 is carried by each strobe above

		if (accept) begin
			if (cmd.preset) begin
				st_nxt.mask = '0; // RULE_15
				st_nxt.resp.valid = 1'b1;
			end else if (cmd.wr) begin
				st_nxt.resp.valid = 1'b1;
				// out-of-range values are refused whole, never truncated
				if (sfef_sel_ok(cmd.sel) && wr_digits_ok && wr_value <= SFEF_MASK_MAX) begin
					st_nxt.mask[cmd.sel] = wr_value[SFEF_MASK_W-1:0]; // RULE_01 RULE_06
				end else begin
					st_nxt.resp.err = 1'b1;
				end
			end else if (cmd.rd) begin
				if (sfef_sel_ok(cmd.sel)) begin
					st_nxt.busy = 1'b1;
				end else begin
					st_nxt.resp.valid = 1'b1;
					st_nxt.resp.err = 1'b1;
				end
			end else begin
				st_nxt.resp.valid = 1'b1; // RULE_16
			end
		end

		if (st_r.busy && conv_done) begin
			st_nxt.busy = 1'b0;
			st_nxt.resp.valid = 1'b1;
			st_nxt.resp.bcd = conv_bcd; // RULE_05
		end

		st_nxt.ready = ~st_nxt.busy;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0; // RULE_16
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_ready = st_r.ready;
	assign resp = st_r.resp;
	assign event_set = st_r.ev;

endmodule

// ==== sfef_pkg.sv ====
// constants and carrier types of the falling-edge status filter bank
// assumes one 50 MHz clock domain; condition bits arrive from logic on that clock
//
// Overview of operation
// RULE_01 - five falling masks: operation, trigger, arm, sequence, questionable; all read/write.
// RULE_02 - a falling transition is a condition bit going from one to zero.
// RULE_03 - mask bit set and condition bit falls: matching event bit is set.
// RULE_04 - host writes a mask as one decimal sum of bit weights.
// RULE_05 - a mask query answers a decimal whose binary ones are the mask bits.
// RULE_06 - operation mask bit six weighs 64 (arm), bit five weighs 32 (trigger).
// RULE_07 - operation bit one sets when the relay settling period ends.
// RULE_08 - operation bit five sets when the sequencer leaves the trigger layer.
// RULE_09 - operation bit six sets when the sequencer leaves any arm layer.
// RULE_10 - operation bit ten sets when the instrument leaves idle.
// RULE_11 - trigger bit one sets for sequence one on leaving the trigger layer.
// RULE_12 - arm bit one sets for sequence one on leaving an arm layer.
// RULE_13 - sequence bits one and two set on leaving arm layers one and two.
// RULE_14 - questionable bit nine sets when channels reopen after too-many-closed error.
// RULE_15 - status preset clears every bit of all falling masks.
// RULE_16 - masks clear at power-up; clear-status command leaves them unchanged.
package sfef_pkg;

	localparam int SFEF_SETS = 5;
	localparam int SFEF_MASK_W = 16;
	localparam int SFEF_BCD_W = 20;
	localparam logic [15:0] SFEF_MASK_RESET = 16'h0000;
	localparam logic [16:0] SFEF_MASK_MAX = 17'h0ffff;

	// register sets, also the index of each mask
	typedef enum logic [2:0] {
		SFEF_OPER = 3'h0,
		SFEF_TRIG = 3'h1,
		SFEF_ARM = 3'h2,
		SFEF_SEQ = 3'h3,
		SFEF_QUES = 3'h4
	} sfef_set_type;

	// documented bit positions
	localparam int SFEF_OPER_SETTLE = 1;
	localparam int SFEF_OPER_TRIG = 5;
	localparam int SFEF_OPER_ARM = 6;
	localparam int SFEF_OPER_IDLE = 10;
	localparam int SFEF_TRIG_SEQ1 = 1;
	localparam int SFEF_ARM_SEQ1 = 1;
	localparam int SFEF_SEQ_LAYER1 = 1;
	localparam int SFEF_SEQ_LAYER2 = 2;
	localparam int SFEF_QUES_CHAN = 9;

	// double-dabble shifts for a 16-bit mask
	localparam logic [3:0] SFEF_LAST_SHIFT = 4'hf;

	typedef struct packed {
		logic wr;
		logic rd;
		logic preset;
		logic clr_status;
		sfef_set_type sel;
		logic [SFEF_BCD_W-1:0] bcd;
	} sfef_cmd_type;

	typedef struct packed {
		logic valid;
		logic err;
		logic [SFEF_BCD_W-1:0] bcd;
	} sfef_resp_type;

endpackage

// ==== sfef_bin2bcd.sv ====
// serial binary to packed-decimal converter for mask queries
// assumes start only while idle; done is a one-cycle pulse 16 cycles after start
module sfef_bin2bcd
	import sfef_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [SFEF_MASK_W-1:0] bin,
	output logic done,
	output logic [SFEF_BCD_W-1:0] bcd
);

	typedef enum logic [1:0] {
		SFEF_CV_IDLE = 2'b00,
		SFEF_CV_SHIFT = 2'b01,
		SFEF_CV_DONE = 2'b11
	} sfef_cv_state_type;

	typedef struct packed {
		sfef_cv_state_type state;
		logic [3:0] cnt;
		logic [SFEF_BCD_W+SFEF_MASK_W-1:0] sh;
	} sfef_cv_type;

	sfef_cv_type cv_r;
	sfef_cv_type cv_nxt;

	function automatic logic [SFEF_BCD_W-1:0] sfef_adjust(input logic [SFEF_BCD_W-1:0] d);
		logic [SFEF_BCD_W-1:0] r;
		r = d;
		for (int i = 0; i < SFEF_BCD_W / 4; i++) begin
			if (r[i*4 +: 4] > 4'h4) begin
				r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
			end
		end
		return r;
	endfunction

	always_comb begin
		cv_nxt = cv_r;
		case (cv_r.state)
			SFEF_CV_IDLE: begin
				if (start) begin
					cv_nxt.sh = {{SFEF_BCD_W{1'b0}}, bin};
					cv_nxt.cnt = 4'h0;
					cv_nxt.state = SFEF_CV_SHIFT;
				end
			end
			SFEF_CV_SHIFT: begin
				cv_nxt.sh = {sfef_adjust(cv_r.sh[SFEF_BCD_W+SFEF_MASK_W-1:SFEF_MASK_W]),
					cv_r.sh[SFEF_MASK_W-1:0]} << 1;
				cv_nxt.cnt = cv_r.cnt + 4'h1;
				if (cv_r.cnt == SFEF_LAST_SHIFT) begin
					cv_nxt.state = SFEF_CV_DONE;
				end
			end
			SFEF_CV_DONE: begin
				cv_nxt.state = SFEF_CV_IDLE;
			end
			default: begin
				cv_nxt.state = SFEF_CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cv_r <= '0;
		end else begin
			cv_r <= cv_nxt;
		end
	end

	assign done = (cv_r.state == SFEF_CV_DONE);
	assign bcd = cv_r.sh[SFEF_BCD_W+SFEF_MASK_W-1:SFEF_MASK_W];

endmodule

// ==== sfef_host.sv ====
// host model: sends mask commands as packed decimal sums
// assumes the filter's port on sys_clk; drives at the falling edge
module sfef_host
	import sfef_pkg::*;
(
	input wire logic sys_clk,
	input wire logic cmd_ready,
	input wire sfef_resp_type resp,
	output sfef_cmd_type cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cmd = '0;
	function automatic logic [19:0] dec(input int v);
		dec = '0;
		for (int i = 0; i < 5; i++) begin
			dec[i*4+:4] = 4'(v % 10);
			v = v / 10;
		end
	endfunction
	// held until an edge with ready high; bounded waits
	task automatic xfer(input sfef_cmd_type c, output sfef_resp_type r);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd = c;
		while (!cmd_ready && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		cmd = '0;
		while (!resp.valid && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		r = resp;
	endtask
endmodule

// ==== sfef_filter_chk.sv ====
// port assertions of the falling-edge filter
// assumes one sys_clk domain, async rst high
module sfef_filter_chk
	import sfef_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire sfef_cmd_type cmd,
	input wire logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] cond,
	input wire logic cmd_ready,
	input wire sfef_resp_type resp,
	input wire logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] event_set
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic go;
	logic q_go;
	assign go = cmd_ready && !cmd.preset && !cmd.wr;
	assign q_go = go && cmd.rd && cmd.sel <= SFEF_QUES;
	for (genvar s = 0; s < 5; s++) begin : g_s
		for (genvar b = 0; b < 16; b++) begin : g_b
			a_fall_cause: assert property (event_set[s][b] |->
				$past(cond[s][b], 2) && !$past(cond[s][b])) else $error("strobe without fall");
		end
	end
	a_quiet_bits: assert property ((event_set[0] & ~16'h0462) == 16'h0 &&
		(event_set[1] & ~16'h0002) == 16'h0 && (event_set[2] & ~16'h0002) == 16'h0 &&
		(event_set[3] & ~16'h0006) == 16'h0 && (event_set[4] & ~16'h0200) == 16'h0)
		else $error("undocumented strobe");
	a_preset_ack: assert property (cmd_ready && cmd.preset |=> resp.valid && !resp.err)
		else $error("preset not acknowledged");
	a_clr_ack: assert property (go && !cmd.rd && cmd.clr_status |=> resp.valid && !resp.err)
		else $error("clear-status not acknowledged");
	a_bad_sel: assert property (cmd_ready && cmd.wr && !cmd.preset && cmd.sel > SFEF_QUES
		|=> resp.valid && resp.err) else $error("bad select accepted");
	// answer registers at the 17th edge after the taking edge, so it is sampled at the 18th
	a_query_time: assert property (q_go |-> ##18 resp.valid && !resp.err && cmd_ready)
		else $error("query answer late");
	a_query_busy: assert property (q_go |=> (!cmd_ready && !resp.valid) [*8] ##1
		(!cmd_ready && !resp.valid) [*8] ##1 (!cmd_ready && !resp.valid))
		else $error("query not busy");
	a_bcd_hold: assert property ($changed(resp.bcd) |-> resp.valid)
		else $error("answer changed unasked");
endmodule
bind sfef_filter sfef_filter_chk chk (.sys_clk, .rst, .cmd, .cond, .cmd_ready, .resp, .event_set);

// ==== sfef_tb.sv ====
// self-checking bench of the falling-edge filter masks
// assumes sfef_host issues commands; cond driven at falling edge
module testbench
	import sfef_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] cond = '0;
	logic [SFEF_SETS-1:0][SFEF_MASK_W-1:0] event_set;
	logic cmd_ready;
	sfef_cmd_type cmd;
	sfef_resp_type resp;
	sfef_resp_type r;
	int mval[5] = '{1122, 2, 2, 6, 512};
	int miscompares = 0;
	int samples_checked = 0;
	always #10 sys_clk = ~sys_clk;
	sfef_filter dut (.sys_clk, .rst, .cmd, .cond, .cmd_ready, .resp, .event_set);
	sfef_host host (.sys_clk, .cmd_ready, .resp, .cmd);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic end_sim();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// k: wr, rd, preset, clr_status
	task automatic op(input logic [3:0] k, input sfef_set_type s, input logic [19:0] v, input logic e);
		host.xfer({k, s, v}, r);
		chk("valid", 20'h1, 20'(r.valid));
		chk("err", 20'(e), 20'(r.err));
	endtask
	task automatic q(input sfef_set_type s, input int v);
		op(4'h4, s, 20'h0, 1'b0);
		chk("mask", host.dec(v), r.bcd);
	endtask
	task automatic w(input sfef_set_type s, input int v);
		op(4'h8, s, host.dec(v), 1'b0);
	endtask
	task automatic fall(input int s, input int b, input logic x);
		@(negedge sys_clk);
		cond[s][b] = 1'b1;
		@(negedge sys_clk);
		cond[s][b] = 1'b0;
		chk("rise", 20'h0, 20'(event_set[s]));
		@(negedge sys_clk);
		chk("fall", 20'(x) << b, 20'(event_set[s]));
		@(negedge sys_clk);
		chk("once", 20'h0, 20'(event_set[s]));
	endtask
	////////////////////////////////////////
	task automatic t_rw();
		for (int i = 0; i < 5; i++) begin
			q(sfef_set_type'(i), 0);
		end
		w(SFEF_OPER, 96);
		q(SFEF_OPER, 96);
		w(SFEF_QUES, 65535);
		q(SFEF_QUES, 65535);
		for (int i = 0; i < 5; i++) begin
			w(sfef_set_type'(i), mval[i]);
			q(sfef_set_type'(i), mval[i]);
		end
		op(4'h1, SFEF_OPER, 20'h0, 1'b0);
		q(SFEF_OPER, 1122);
	endtask
	task automatic t_events();
		fall(0, 1, 1'b1);
		fall(0, 5, 1'b1);
		fall(0, 6, 1'b1);
		fall(0, 10, 1'b1);
		fall(1, 1, 1'b1);
		fall(2, 1, 1'b1);
		fall(3, 1, 1'b1);
		fall(3, 2, 1'b1);
		fall(4, 9, 1'b1);
		w(SFEF_OPER, 1120);
		fall(0, 1, 1'b0);
		fall(0, 10, 1'b1);
	endtask
	task automatic t_bad();
		op(4'h8, sfef_set_type'(5), host.dec(3), 1'b1);
		op(4'h8, SFEF_OPER, 20'h0000a, 1'b1);
		op(4'h8, SFEF_OPER, host.dec(65536), 1'b1);
		op(4'h4, sfef_set_type'(6), 20'h0, 1'b1);
		q(SFEF_OPER, 1120);
	endtask
	task automatic t_preset();
		op(4'h2, SFEF_OPER, 20'h0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			q(sfef_set_type'(i), 0);
		end
		fall(4, 9, 1'b0);
	endtask
	// mid-run reset: the arm mask must come back cleared, no command taken while held
	task automatic t_reset();
		w(SFEF_ARM, 2);
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("ready", 20'h0, 20'(cmd_ready));
		rst = 1'b0;
		q(SFEF_ARM, 0);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		t_rw();
		t_events();
		t_bad();
		t_preset();
		t_reset();
		end_sim();
	end
	// a few hundred cycles expected
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
endmodule
